// *** vct_vc_layer.v ***
// Functional notes
// - Matrix entries join a chosen input to an output; clearing removes it.
// - Each entry holds kind, one-way or two-way, and port ids.
// - Several outputs may take the same input at once.
// - Unconnected output sends no cells and server fail low.
// - Input server fail not marked connected is taken as false.
// - Source sends remote defect cells while sink requests, stops after.
// - Remote defect cell carries sink data, or 6A bytes if unused.
// - Option one: insert check cell after a second without cells.
// - Option two: insert one check cell per second always.
// - Monitoring enabled: forward cells, backward cells from sink results.
// - Management requests produce activate or deactivate cells.
// - Management responses produce confirm, deny or deactivate-confirm cells.
// - Sink strips all end-to-end OAM cells from the stream.
// - Remote defect cell: store fields, report, enter remote defect.
// - Remote defect clears after over 2.5 s without such cells.
// - Alarm cell: store fields, report, enter alarm state.
// - User or check cell ends the alarm state.
// - Without checking, alarm also ends after 2.5 s without alarm cells.
// - Received activate cell raises a request toward management.
// - Received confirm or deny cells raise a report toward management.
// - Stray segment OAM cells are discarded at the sink.
// - Checking on: continuity loss after 3.5 s silence, clear on cell.
// - Trail fail and remote defect follow server fail, loss or alarm.
// - Alarm fault reporting is a setting, off after reset.
`timescale 1ns/10ps
`default_nettype none
`include "vct_consts.vh"
module vct_vc_layer #(
  parameter [23:0] TICK_CYCLES = `VCT_TICK_CYCLES
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  input wire [3:0] mx_in_valid,
  input wire [7:0] mx_in_kind,
  input wire [15:0] mx_in_code,
  input wire [63:0] mx_in_info,
  input wire [3:0] mx_in_ssf,
  output reg [3:0] mx_out_valid,
  output reg [7:0] mx_out_kind,
  output reg [15:0] mx_out_code,
  output reg [63:0] mx_out_info,
  output reg [3:0] mx_out_ssf,
  input wire src_in_valid,
  input wire [15:0] src_in_info,
  output reg src_out_valid,
  output reg [1:0] src_out_kind,
  output reg [3:0] src_out_code,
  output reg [15:0] src_out_info,
  input wire sink_in_valid,
  input wire [1:0] sink_in_kind,
  input wire [3:0] sink_in_code,
  input wire [15:0] sink_in_info,
  input wire sink_ssf,
  output reg sink_out_valid,
  output reg [15:0] sink_out_info,
  output wire sink_tsf
);
  reg [31:0] ctrl;
  reg [23:0] prescale;
  reg [31:0] matrix;
  reg [3:0] ssf_conn;
  reg [15:0] defect_info;
  reg [3:0] events;
  reg [15:0] rdi_data;
  reg [15:0] ais_data;
  reg [15:0] brpm;
  reg [23:0] pre_cnt;
  reg tick;
  reg [3:0] rdi_age;
  reg [3:0] ais_age;
  reg [3:0] loc_age;
  reg rdi_def;
  reg ais_def;
  reg loc_def;
  reg [7:0] blk_cnt;
  reg [15:0] user_cnt;
  reg [3:0] idle_age;
  reg [3:0] per_age;
  reg [3:0] rdi_gap;
  reg p_rdi;
  reg p_cc;
  reg p_pmf;
  reg p_pmb;
  reg p_req;
  reg [3:0] p_req_code;
  reg p_req_pm;
  reg p_rsp;
  reg [3:0] p_rsp_code;
  reg p_rsp_pm;
  reg [3:0] next_events;
  reg [3:0] sel_v;
  reg [7:0] sel_s;
  integer j;
  integer k;
  integer m;
  wire cc_en = ctrl[`VCT_C_CC_EN];
  wire pm_en = ctrl[`VCT_C_PM_EN];
  wire [3:0] tol = ctrl[`VCT_C_TOL_LO+3:`VCT_C_TOL_LO];
  // Limits kept one bit wider so a large tolerance cannot wrap
  wire [4:0] rdi_lim = {1'b0, `VCT_AIS_RDI_TICKS} + {1'b0, tol};
  wire [4:0] loc_lim = {1'b0, `VCT_LOC_TICKS} + {1'b0, tol};
  wire wr = psel & penable & pwrite;
  wire rd_ok;
  wire s_user = sink_in_valid && sink_in_kind == `VCT_K_USER;
  wire s_oam = sink_in_valid && sink_in_kind == `VCT_K_E2E;
  wire s_cc = s_oam && sink_in_code == `VCT_O_CC;
  wire remote_req;
  wire [15:0] remote_data;
  wire mgmt_wr = wr && paddr == `VCT_MGMT;

  function [3:0] age_inc;
    input [3:0] age;
    input t;
    begin
      age_inc = (t && age != 4'hF) ? age + 4'h1 : age;
    end
  endfunction

  function [3:0] resp_code;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: resp_code = `VCT_O_CONF;
        2'h1: resp_code = `VCT_O_DENY;
        default: resp_code = `VCT_O_DCONF;
      endcase
    end
  endfunction

  assign pready = 1'b1;
  assign rd_ok = paddr == `VCT_CTRL || paddr == `VCT_PRESCALE ||
    paddr == `VCT_MATRIX || paddr == `VCT_SSF_CONN ||
    paddr == `VCT_MGMT || paddr == `VCT_STATUS ||
    paddr == `VCT_EVENTS || paddr == `VCT_RDI_DATA ||
    paddr == `VCT_AIS_DATA || paddr == `VCT_BRPM ||
    paddr == `VCT_DEFECT_INFO;

  always @* begin
    pslverr = psel & penable & ~rd_ok;
    case (paddr)
      `VCT_CTRL: prdata = ctrl;
      `VCT_PRESCALE: prdata = {8'h00, prescale};
      `VCT_MATRIX: prdata = matrix;
      `VCT_SSF_CONN: prdata = {28'h0000000, ssf_conn};
      `VCT_STATUS: prdata = {25'h0000000, sink_tsf,
        loc_def & ~sink_ssf & ~ais_def,
        ais_def & ~sink_ssf & ctrl[`VCT_C_AIS_REP],
        rdi_def & ctrl[`VCT_C_RDI_REP],
        loc_def, ais_def, rdi_def};
      `VCT_EVENTS: prdata = {28'h0000000, events};
      `VCT_RDI_DATA: prdata = {16'h0000, rdi_data};
      `VCT_AIS_DATA: prdata = {16'h0000, ais_data};
      `VCT_BRPM: prdata = {16'h0000, brpm};
      `VCT_DEFECT_INFO: prdata = {16'h0000, defect_info};
      default: prdata = 32'h0000_0000;
    endcase
  end

  // Register writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `VCT_CTRL_RST;
      prescale <= TICK_CYCLES;
      matrix <= 32'h0000_0000;
      ssf_conn <= 4'h0;
      defect_info <= `VCT_INFO_RST;
    end else if (wr) begin
      case (paddr)
        `VCT_CTRL: ctrl <= pwdata;
        `VCT_PRESCALE: prescale <= pwdata[23:0];
        `VCT_MATRIX: matrix <= pwdata;
        `VCT_SSF_CONN: ssf_conn <= pwdata[3:0];
        `VCT_DEFECT_INFO: defect_info <= pwdata[15:0];
        default: ctrl <= ctrl;
      endcase
    end
  end

  // Routing: byte j = {dir, kind, src[1:0], en}; two-way adds reverse path
  always @* begin
    for (j = 0; j < 4; j = j + 1) begin
      sel_v[j] = 1'b0;
      sel_s[2*j +: 2] = 2'h0;
      for (k = 0; k < 4; k = k + 1) begin
        if (matrix[8*k] && k == j) begin
          sel_v[j] = 1'b1;
          sel_s[2*j +: 2] = matrix[8*k+1 +: 2];
        end
        if (matrix[8*k] && matrix[8*k+4] &&
            matrix[8*k+1 +: 2] == j[1:0]) begin
          sel_v[j] = 1'b1;
          sel_s[2*j +: 2] = k[1:0];
        end
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mx_out_valid <= 4'h0;
      mx_out_kind <= 8'h00;
      mx_out_code <= 16'h0000;
      mx_out_info <= 64'h0;
      mx_out_ssf <= 4'h0;
    end else begin
      for (m = 0; m < 4; m = m + 1) begin
        mx_out_valid[m] <= sel_v[m] &
          mx_in_valid[sel_s[2*m +: 2]];
        mx_out_kind[2*m +: 2] <= mx_in_kind[2*sel_s[2*m +: 2] +: 2];
        mx_out_code[4*m +: 4] <= mx_in_code[4*sel_s[2*m +: 2] +: 4];
        mx_out_info[16*m +: 16] <= mx_in_info[16*sel_s[2*m +: 2] +: 16];
        mx_out_ssf[m] <= sel_v[m] & mx_in_ssf[sel_s[2*m +: 2]] &
          ssf_conn[sel_s[2*m +: 2]];
      end
    end
  end

  // Half-second tick
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt <= 24'h000000;
      tick <= 1'b0;
    end else begin
      tick <= pre_cnt + 24'h000001 >= prescale;
      pre_cnt <= (pre_cnt + 24'h000001 >= prescale) ? 24'h000000 :
        pre_cnt + 24'h000001;
    end
  end

  // Sink defects
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdi_def <= 1'b0;
      ais_def <= 1'b0;
      loc_def <= 1'b0;
      rdi_age <= 4'h0;
      ais_age <= 4'h0;
      loc_age <= 4'h0;
      rdi_data <= 16'h0000;
      ais_data <= 16'h0000;
      sink_out_valid <= 1'b0;
      sink_out_info <= 16'h0000;
      user_cnt <= 16'h0000;
      brpm <= 16'h0000;
    end else begin
      sink_out_valid <= s_user;
      sink_out_info <= sink_in_info;
      rdi_age <= age_inc(rdi_age, tick);
      ais_age <= age_inc(ais_age, tick);
      loc_age <= age_inc(loc_age, tick);
      if (s_user && pm_en)
        user_cnt <= user_cnt + 16'h0001;
      if (s_oam && sink_in_code == `VCT_O_PMF)
        brpm <= user_cnt;
      if ({1'b0, rdi_age} > rdi_lim)
        rdi_def <= 1'b0;
      if (!cc_en && {1'b0, ais_age} > rdi_lim)
        ais_def <= 1'b0;
      if (cc_en && {1'b0, loc_age} >= loc_lim)
        loc_def <= 1'b1;
      if (!cc_en)
        loc_def <= 1'b0;
      if (s_user || s_cc) begin
        ais_def <= 1'b0;
        loc_def <= 1'b0;
        loc_age <= 4'h0;
      end
      if (s_oam && sink_in_code == `VCT_O_RDI) begin
        rdi_def <= 1'b1;
        rdi_data <= sink_in_info;
        rdi_age <= 4'h0;
      end
      if (s_oam && sink_in_code == `VCT_O_AIS) begin
        ais_def <= 1'b1;
        ais_data <= sink_in_info;
        ais_age <= 4'h0;
      end
    end
  end

  assign sink_tsf = sink_ssf | loc_def | ais_def;
  assign remote_req = sink_tsf;
  assign remote_data = !ctrl[`VCT_C_FIELDS] ? {`VCT_FILL, `VCT_FILL} :
    ais_def ? ais_data : defect_info;

  // Management events, bit set beats write-one clear
  always @* begin
    next_events = events;
    if (wr && paddr == `VCT_EVENTS)
      next_events = events & ~pwdata[3:0];
    if (s_oam && sink_in_code == `VCT_O_ACT)
      next_events[{1'b0, sink_in_info[15]}] = 1'b1;
    if (s_oam && (sink_in_code == `VCT_O_CONF ||
        sink_in_code == `VCT_O_DENY || sink_in_code == `VCT_O_DCONF))
      next_events[{1'b1, sink_in_info[15]}] = 1'b1;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      events <= 4'h0;
    else
      events <= next_events;
  end

  // Source insertion
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_age <= 4'h0;
      per_age <= 4'h0;
      rdi_gap <= 4'h0;
      blk_cnt <= 8'h00;
      p_rdi <= 1'b0;
      p_cc <= 1'b0;
      p_pmf <= 1'b0;
      p_pmb <= 1'b0;
      p_req <= 1'b0;
      p_req_code <= 4'h0;
      p_req_pm <= 1'b0;
      p_rsp <= 1'b0;
      p_rsp_code <= 4'h0;
      p_rsp_pm <= 1'b0;
      src_out_valid <= 1'b0;
      src_out_kind <= `VCT_K_USER;
      src_out_code <= 4'h0;
      src_out_info <= 16'h0000;
    end else begin
      idle_age <= age_inc(idle_age, tick);
      per_age <= tick && per_age + 4'h1 >= `VCT_ONE_SEC_TICKS ? 4'h0 :
        age_inc(per_age, tick);
      rdi_gap <= tick && rdi_gap + 4'h1 >= `VCT_ONE_SEC_TICKS ? 4'h0 :
        age_inc(rdi_gap, tick);
      if (remote_req && (rdi_gap == 4'h0) && tick)
        p_rdi <= 1'b1;
      if (!remote_req)
        p_rdi <= 1'b0;
      if (cc_en && !ctrl[`VCT_C_CC_OPT2] && idle_age >= `VCT_ONE_SEC_TICKS)
        p_cc <= 1'b1;
      if (cc_en && ctrl[`VCT_C_CC_OPT2] && tick &&
          per_age + 4'h1 >= `VCT_ONE_SEC_TICKS)
        p_cc <= 1'b1;
      if (src_in_valid && pm_en) begin
        blk_cnt <= blk_cnt + 8'h01;
        if (blk_cnt + 8'h01 == `VCT_PM_BLOCK)
          p_pmf <= 1'b1;
      end
      if (pm_en && s_oam && sink_in_code == `VCT_O_PMF)
        p_pmb <= 1'b1;
      if (mgmt_wr && |pwdata[`VCT_M_PM_DEACT:`VCT_M_CC_ACT]) begin
        p_req <= 1'b1;
        p_req_pm <= pwdata[`VCT_M_PM_ACT] | pwdata[`VCT_M_PM_DEACT];
        p_req_code <= (pwdata[`VCT_M_CC_ACT] | pwdata[`VCT_M_PM_ACT]) ?
          `VCT_O_ACT : `VCT_O_DEACT;
      end
      if (mgmt_wr && |pwdata[`VCT_M_PM_RESP:`VCT_M_CC_RESP]) begin
        p_rsp <= 1'b1;
        p_rsp_pm <= pwdata[`VCT_M_PM_RESP];
        p_rsp_code <= resp_code(pwdata[`VCT_M_RESP_LO+1:`VCT_M_RESP_LO]);
      end
      src_out_valid <= 1'b1;
      src_out_kind <= `VCT_K_E2E;
      src_out_info <= 16'h0000;
      if (src_in_valid) begin
        src_out_kind <= `VCT_K_USER;
        src_out_code <= 4'h0;
        src_out_info <= src_in_info;
        idle_age <= 4'h0;
      end else if (p_rsp) begin
        src_out_code <= p_rsp_code;
        src_out_info <= {p_rsp_pm, 15'h0000};
        p_rsp <= 1'b0;
      end else if (p_req) begin
        src_out_code <= p_req_code;
        src_out_info <= {p_req_pm, 15'h0000};
        p_req <= 1'b0;
      end else if (p_rdi && remote_req) begin
        src_out_code <= `VCT_O_RDI;
        src_out_info <= remote_data;
        p_rdi <= 1'b0;
      end else if (p_cc && cc_en) begin
        src_out_code <= `VCT_O_CC;
        p_cc <= 1'b0;
        idle_age <= 4'h0;
      end else if (p_pmf && pm_en) begin
        src_out_code <= `VCT_O_PMF;
        src_out_info <= blk_cnt == 8'h00 ? {8'h00, `VCT_PM_BLOCK} : 16'h0000;
        p_pmf <= 1'b0;
      end else if (p_pmb && pm_en) begin
        src_out_code <= `VCT_O_PMB;
        src_out_info <= brpm;
        p_pmb <= 1'b0;
      end else begin
        src_out_valid <= 1'b0;
        src_out_kind <= `VCT_K_USER;
        src_out_code <= 4'h0;
      end
    end
  end
endmodule
`default_nettype wire

// *** vct_consts.vh ***
`ifndef VCT_CONSTS_VH
`define VCT_CONSTS_VH
// Register byte offsets
`define VCT_CTRL 8'h00
`define VCT_PRESCALE 8'h04
`define VCT_MATRIX 8'h08
`define VCT_SSF_CONN 8'h0C
`define VCT_MGMT 8'h10
`define VCT_STATUS 8'h14
`define VCT_EVENTS 8'h18
`define VCT_RDI_DATA 8'h1C
`define VCT_AIS_DATA 8'h20
`define VCT_BRPM 8'h24
`define VCT_DEFECT_INFO 8'h28
// Control fields
`define VCT_C_CC_EN 0
`define VCT_C_CC_OPT2 1
`define VCT_C_PM_EN 2
`define VCT_C_AIS_REP 3
`define VCT_C_RDI_REP 4
`define VCT_C_FIELDS 5
`define VCT_C_TOL_LO 8
`define VCT_CTRL_RST 32'h0000_0000
`define VCT_INFO_RST 16'h0000
// Management write fields
`define VCT_M_CC_ACT 0
`define VCT_M_CC_DEACT 1
`define VCT_M_PM_ACT 2
`define VCT_M_PM_DEACT 3
`define VCT_M_CC_RESP 4
`define VCT_M_PM_RESP 5
`define VCT_M_RESP_LO 8
// Cell kinds and OAM codes
`define VCT_K_USER 2'h0
`define VCT_K_E2E 2'h1
`define VCT_K_SEG 2'h2
`define VCT_O_AIS 4'h1
`define VCT_O_RDI 4'h2
`define VCT_O_CC 4'h3
`define VCT_O_PMF 4'h4
`define VCT_O_PMB 4'h5
`define VCT_O_ACT 4'h6
`define VCT_O_DEACT 4'h7
`define VCT_O_CONF 4'h8
`define VCT_O_DENY 4'h9
`define VCT_O_DCONF 4'hA
`define VCT_FILL 8'h6A
// Timing: base tick is half a second
`define VCT_CLK_NS 100
`define VCT_HALF_SEC_NS 500000000
`define VCT_TICK_CYCLES 24'h4C4B40
`define VCT_ONE_SEC_TICKS 4'h2
`define VCT_AIS_RDI_TICKS 4'h5
`define VCT_LOC_TICKS 4'h7
`define VCT_PM_BLOCK 8'h80
`endif

// *** vct_chk.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "vct_consts.vh"
module vct_chk #(
  parameter [23:0] TICK_CYCLES = 24'h14
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] mx_in_valid,
  input wire [3:0] mx_out_valid,
  input wire [3:0] mx_out_ssf,
  input wire src_out_valid,
  input wire [1:0] src_out_kind,
  input wire [3:0] src_out_code,
  input wire sink_in_valid,
  input wire [1:0] sink_in_kind,
  input wire [15:0] sink_in_info,
  input wire sink_ssf,
  input wire sink_out_valid,
  input wire [15:0] sink_out_info,
  input wire sink_tsf
);
  reg [31:0] mtx, mtx_q;
  reg [3:0] sc, sc_q, tsf_age;
  wire wr = psel && penable && pwrite;
  wire mx_on = |{mtx[0], mtx[8], mtx[16], mtx[24],
                 mtx_q[0], mtx_q[8], mtx_q[16], mtx_q[24]};
  // Shadow of matrix and server-fail wiring, tsf age
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mtx <= 32'h0;
      mtx_q <= 32'h0;
      sc <= 4'h0;
      sc_q <= 4'h0;
      tsf_age <= 4'hF;
    end else begin
      mtx_q <= mtx;
      sc_q <= sc;
      if (wr && paddr == `VCT_MATRIX) mtx <= pwdata;
      if (wr && paddr == `VCT_SSF_CONN) sc <= pwdata[3:0];
      if (sink_tsf) tsf_age <= 4'h0;
      else if (tsf_age != 4'hF) tsf_age <= tsf_age + 4'h1;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_idle_matrix_out: assert property (
    !mx_on |-> mx_out_valid == 4'h0 && mx_out_ssf == 4'h0)
    else $error("Unconnected output active");
  chk_ssf_unwired: assert property (
    sc == 4'h0 && sc_q == 4'h0 |-> mx_out_ssf == 4'h0)
    else $error("Unwired server fail passed on");
  chk_mx_cause: assert property (
    mx_out_valid != 4'h0 |-> $past(mx_in_valid) != 4'h0)
    else $error("Matrix cell without input cell");
  chk_sink_user_pass: assert property (
    sink_in_valid && sink_in_kind == `VCT_K_USER |=>
    sink_out_valid && sink_out_info == $past(sink_in_info))
    else $error("User cell not passed by sink");
  chk_sink_oam_drop: assert property (
    sink_out_valid |-> $past(sink_in_valid) &&
    $past(sink_in_kind) == `VCT_K_USER)
    else $error("Sink passed a non-user cell");
  chk_tsf_on_ssf: assert property (
    sink_ssf |-> sink_tsf)
    else $error("Trail fail missing under server fail");
  chk_alarm_end: assert property (
    sink_in_valid && sink_in_kind == `VCT_K_USER && !sink_ssf ##1
    !sink_ssf |-> !sink_tsf)
    else $error("User cell did not end alarm");
  chk_rdi_cause: assert property (
    src_out_valid && src_out_kind == `VCT_K_E2E &&
    src_out_code == `VCT_O_RDI |-> tsf_age < 4'h8)
    else $error("Remote defect cell without request");
  cover property (mx_out_valid == 4'h3);
  cover property ($rose(sink_tsf));
  cover property (src_out_valid && src_out_code == `VCT_O_RDI);
endmodule
bind vct_vc_layer vct_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .mx_in_valid(mx_in_valid), .mx_out_valid(mx_out_valid),
  .mx_out_ssf(mx_out_ssf), .src_out_valid(src_out_valid),
  .src_out_kind(src_out_kind), .src_out_code(src_out_code),
  .sink_in_valid(sink_in_valid), .sink_in_kind(sink_in_kind),
  .sink_in_info(sink_in_info), .sink_ssf(sink_ssf),
  .sink_out_valid(sink_out_valid), .sink_out_info(sink_out_info),
  .sink_tsf(sink_tsf));
`default_nettype wire

// *** vct_far_end.sv ***
`timescale 1ns/10ps
`default_nettype none
module vct_far_end (
  input wire logic pclk,
  input wire logic src_out_valid,
  input wire logic [1:0] src_out_kind,
  input wire logic [3:0] src_out_code,
  input wire logic [15:0] src_out_info,
  output logic sink_in_valid,
  output logic [1:0] sink_in_kind,
  output logic [3:0] sink_in_code,
  output logic [15:0] sink_in_info
);
  int cnt [16];
  logic [15:0] last [16];
  initial begin
    sink_in_valid = 1'b0;
    sink_in_kind = 2'h0;
    sink_in_code = 4'h0;
    sink_in_info = 16'h0000;
    foreach (cnt[i]) cnt[i] = 0;
  end
  // Tally of OAM cells leaving the trail source
  always @(posedge pclk) begin
    if (src_out_valid && src_out_kind == 2'h1) begin
      cnt[src_out_code] = cnt[src_out_code] + 1;
      last[src_out_code] = src_out_info;
    end
  end
  task automatic send(input logic [1:0] k, input logic [3:0] c,
                      input logic [15:0] i);
    @(posedge pclk);
    sink_in_valid <= 1'b1;
    sink_in_kind <= k;
    sink_in_code <= c;
    sink_in_info <= i;
    @(posedge pclk);
    sink_in_valid <= 1'b0;
    sink_in_info <= ~i; // Released data no longer valid
  endtask
endmodule
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "vct_consts.vh"
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, src_in_valid, sink_ssf, err;
  logic [7:0] paddr, mx_in_kind;
  logic [31:0] pwdata, rd;
  logic [3:0] mx_in_valid, mx_in_ssf;
  logic [63:0] mx_in_info;
  logic [15:0] src_in_info;
  wire [31:0] prdata;
  wire pready, pslverr, src_out_valid, sink_out_valid, sink_tsf;
  wire sink_in_valid;
  wire [3:0] mx_out_valid, mx_out_ssf, src_out_code, sink_in_code;
  wire [7:0] mx_out_kind;
  wire [15:0] mx_out_code, src_out_info, sink_in_info, sink_out_info;
  wire [63:0] mx_out_info;
  wire [1:0] src_out_kind, sink_in_kind;
  int miscompares, n_checks, cyc, n;
  vct_vc_layer #(.TICK_CYCLES(24'h14)) uut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mx_in_valid(mx_in_valid), .mx_in_kind(mx_in_kind),
    .mx_in_code(16'h0000), .mx_in_info(mx_in_info), .mx_in_ssf(mx_in_ssf),
    .mx_out_valid(mx_out_valid), .mx_out_kind(mx_out_kind),
    .mx_out_code(mx_out_code), .mx_out_info(mx_out_info),
    .mx_out_ssf(mx_out_ssf), .src_in_valid(src_in_valid),
    .src_in_info(src_in_info), .src_out_valid(src_out_valid),
    .src_out_kind(src_out_kind), .src_out_code(src_out_code),
    .src_out_info(src_out_info), .sink_in_valid(sink_in_valid),
    .sink_in_kind(sink_in_kind), .sink_in_code(sink_in_code),
    .sink_in_info(sink_in_info), .sink_ssf(sink_ssf),
    .sink_out_valid(sink_out_valid), .sink_out_info(sink_out_info),
    .sink_tsf(sink_tsf));
  vct_far_end fe (.pclk(pclk), .src_out_valid(src_out_valid),
    .src_out_kind(src_out_kind), .src_out_code(src_out_code),
    .src_out_info(src_out_info), .sink_in_valid(sink_in_valid),
    .sink_in_kind(sink_in_kind), .sink_in_code(sink_in_code),
    .sink_in_info(sink_in_info));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      miscompares++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  initial begin
    {presetn, psel, penable, pwrite, src_in_valid, sink_ssf} = 6'h00;
    {paddr, pwdata, src_in_info} = 56'h0;
    {mx_in_valid, mx_in_ssf, mx_in_info, mx_in_kind} = 80'h0;
    {miscompares, n_checks, cyc} = 96'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(`VCT_CTRL, 32'h0);
    rdchk(`VCT_PRESCALE, 32'h14);
    apb(1'b0, 8'h3C, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("Test registers done");
    apb(1'b1, `VCT_MATRIX, 32'h0303);
    @(posedge pclk);
    mx_in_valid <= 4'h2;
    mx_in_ssf <= 4'h2;
    mx_in_kind <= 8'h04;
    mx_in_info <= 64'h0000_0000_5A5A_0000;
    src_in_valid <= 1'b1;
    src_in_info <= 16'hC3C3;
    @(posedge pclk);
    mx_in_valid <= 4'h0;
    src_in_valid <= 1'b0;
    #1;
    chk({28'h0, mx_out_valid}, 32'h3);
    chk(mx_out_info[31:0], 32'h5A5A5A5A);
    chk({24'h0, mx_out_kind}, 32'h5);
    chk({28'h0, mx_out_ssf}, 32'h0);
    chk({13'h0, src_out_valid, src_out_kind, src_out_info}, 32'h4C3C3);
    apb(1'b1, `VCT_SSF_CONN, 32'h2);
    repeat (2) @(posedge pclk);
    #1 chk({28'h0, mx_out_ssf}, 32'h3);
    apb(1'b1, `VCT_MATRIX, 32'h0);
    repeat (2) @(posedge pclk);
    #1 chk({28'h0, mx_out_ssf}, 32'h0);
    mx_in_ssf <= 4'h0;
    $display("Test matrix done");
    fe.send(`VCT_K_E2E, `VCT_O_RDI, 16'h1234);
    rdchk(`VCT_STATUS, 32'h1);
    rdchk(`VCT_RDI_DATA, 32'h1234);
    repeat (60) @(posedge pclk);
    rdchk(`VCT_STATUS, 32'h1);
    repeat (100) @(posedge pclk);
    rdchk(`VCT_STATUS, 32'h0);
    fe.send(`VCT_K_E2E, `VCT_O_AIS, 16'h0A0B);
    rdchk(`VCT_STATUS, 32'h42);
    rdchk(`VCT_AIS_DATA, 32'h0A0B);
    repeat (60) @(posedge pclk);
    chk(fe.cnt[`VCT_O_RDI] > 0, 32'h1);
    chk({16'h0, fe.last[`VCT_O_RDI]}, 32'h6A6A);
    fe.send(`VCT_K_USER, 4'h0, 16'h7777);
    rdchk(`VCT_STATUS, 32'h0);
    n = fe.cnt[`VCT_O_RDI];
    fe.send(`VCT_K_SEG, `VCT_O_AIS, 16'h1111);
    repeat (60) @(posedge pclk);
    rdchk(`VCT_STATUS, 32'h0);
    chk(fe.cnt[`VCT_O_RDI], n);
    sink_ssf <= 1'b1;
    repeat (3) @(posedge pclk);
    sink_ssf <= 1'b0;
    $display("Test defects done");
    fe.send(`VCT_K_E2E, `VCT_O_ACT, 16'h0000);
    fe.send(`VCT_K_E2E, `VCT_O_ACT, 16'h8000);
    fe.send(`VCT_K_E2E, `VCT_O_CONF, 16'h0000);
    fe.send(`VCT_K_E2E, `VCT_O_DENY, 16'h8000);
    rdchk(`VCT_EVENTS, 32'hF);
    apb(1'b1, `VCT_EVENTS, 32'hF);
    fe.send(`VCT_K_E2E, `VCT_O_DCONF, 16'h0000);
    rdchk(`VCT_EVENTS, 32'h4);
    for (int i = 0; i < 4; i++) apb(1'b1, `VCT_MGMT, 32'h1 << i);
    for (int r = 0; r < 3; r++) apb(1'b1, `VCT_MGMT, 32'h10 | (r << 8));
    repeat (10) @(posedge pclk);
    chk(fe.cnt[`VCT_O_ACT], 2);
    chk(fe.cnt[`VCT_O_DEACT], 2);
    chk(fe.cnt[`VCT_O_CONF] + fe.cnt[`VCT_O_DENY], 2);
    chk(fe.cnt[`VCT_O_DCONF], 1);
    $display("Test activation done");
    n = fe.cnt[`VCT_O_CC];
    apb(1'b1, `VCT_CTRL, 32'h3);
    repeat (200) @(posedge pclk);
    chk(fe.cnt[`VCT_O_CC] - n >= 4, 32'h1);
    rdchk(`VCT_STATUS, 32'h64);
    fe.send(`VCT_K_USER, 4'h0, 16'h0101);
    rdchk(`VCT_STATUS, 32'h0);
    n = fe.cnt[`VCT_O_CC];
    apb(1'b1, `VCT_CTRL, 32'h1);
    repeat (100) @(posedge pclk);
    chk(fe.cnt[`VCT_O_CC] - n >= 1, 32'h1);
    $display("Test continuity done");
    apb(1'b1, `VCT_CTRL, 32'h4);
    fe.send(`VCT_K_USER, 4'h0, 16'h0202);
    fe.send(`VCT_K_E2E, `VCT_O_PMF, 16'h0000);
    rdchk(`VCT_BRPM, 32'h1);
    chk({16'h0, fe.last[`VCT_O_PMB]}, 32'h1);
    @(posedge pclk);
    src_in_valid <= 1'b1;
    repeat (128) @(posedge pclk);
    src_in_valid <= 1'b0;
    repeat (4) @(posedge pclk);
    chk(fe.cnt[`VCT_O_PMF], 1);
    $display("Test monitoring done");
    print_verdict();
  end
endmodule
`default_nettype wire
